//--- dv/crs_clock_ref_select_asserts.sv
// Checker for the clock reference select block
`timescale 1ns/1ps
`default_nettype none
module crs_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [2:0] ref_lock_i,
  input wire logic [1:0] clk_src_o,
  input wire logic slave_o,
  input wire logic spdif_coax_out_en_o,
  input wire logic boot_backup_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus request taken at this edge
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Bus answer, selection and firmware checks
  ack_answer_a: assert property (take |=> wb_ack_o)
    else $error("ack missing");
  ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  coax_on_a: assert property (spdif_coax_out_en_o)
    else $error("coax output off");
  slave_src_a: assert property (slave_o == (clk_src_o != 2'h3))
    else $error("slave flag mismatch");
  no_lock_a: assert property (ref_lock_i == 3'h0 |=>
    clk_src_o == 2'h3) else $error("no oscillator fallback");
  src_locked_a: assert property (clk_src_o != 2'h3 |->
    ($past(ref_lock_i) >> clk_src_o) & 3'h1) else $error("unlocked source");
  boot_hold_a: assert property (!por_i |=> $stable(boot_backup_o))
    else $error("image changed without cold start");
  status_read_a: assert property (take && !wb_we_i &&
    wb_adr_i == 8'h04 |=> wb_dat_o[8:6] == {$past(slave_o), $past(clk_src_o)})
    else $error("status field mismatch");
  // Main scenarios
  cover property ($rose(slave_o));
  cover property ($rose(irq_o));
  cover property ($rose(boot_backup_o));
endmodule
bind crs_clock_ref_select crs_chk u_chk (.clk_i, .rst_i, .por_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .ref_lock_i,
  .clk_src_o, .slave_o, .spdif_coax_out_en_o, .boot_backup_o, .irq_o);
`default_nettype wire

//--- dv/crs_clock_ref_select_tb_top.sv
// Self-checking bench for the clock reference select block
`timescale 1ns/1ps
`default_nettype none
module crs_clock_ref_select_tb_top import crs_pkg::*;;
  localparam int GATE = 1000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic por_i = 1'b1;
  logic box_p = 1'b0;
  logic box_f = 1'b0;
  logic fl_fail = 1'b0;
  logic fl_done = 1'b0;
  logic [2:0] on = 3'h0;
  logic [2:0] syn = 3'h0;
  logic [11:0] per = 12'h111;
  crs_wb_req_t req = '0;
  logic [31:0] q;
  wire logic [31:0] rdat;
  wire logic ack, slave, div2, coax, oopt, iopt, meta, link, bkp, irq;
  wire logic [1:0] src;
  wire logic [2:0] lock, sync, tick;
  int errors = 0;
  int samples_checked = 0;
  int cur = 3;
  // 10 MHz clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  crs_src_model src_m (.clk_i(clk_i), .on_i(on), .syn_i(syn), .per_i(per),
    .lock_o(lock), .sync_o(sync), .tick_o(tick));
  crs_clock_ref_select #(.GATE_CYCLES(GATE)) uut (.clk_i(clk_i),
    .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr),
    .wb_dat_i(req.dat), .wb_dat_o(rdat), .wb_ack_o(ack), .ref_lock_i(lock),
    .ref_sync_i(sync), .ref_tick_i(tick), .box_present_i(box_p),
    .box_fw_loaded_i(box_f), .flash_fail_i(fl_fail), .flash_done_i(fl_done),
    .clk_src_o(src), .slave_o(slave), .wclk_div2_o(div2),
    .spdif_coax_out_en_o(coax), .spdif_opt_out_en_o(oopt),
    .spdif_in_opt_o(iopt), .metadata_en_o(meta), .box_link_en_o(link),
    .boot_backup_o(bkp), .irq_o(irq));
  // Count and report one comparison
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    req <= {1'b1, 1'b1, w, 4'hf, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    req <= '0;
    if (n >= 20) errors++;
    @(posedge clk_i);
  endtask
  // Register read with masked compare
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(q & m, e);
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Preferred, else current, else next in turn, else oscillator
  function automatic int pick(int p, logic [2:0] l, int c);
    if (l[p]) return p;
    if (c < 3 && l[c]) return c;
    if (l[(p + 1) % 3]) return (p + 1) % 3;
    if (l[(p + 2) % 3]) return (p + 2) % 3;
    return 3;
  endfunction
  // Two-bit lock state per input
  function automatic logic [5:0] lf(input logic [2:0] l, input logic [2:0] s);
    for (int i = 0; i < 3; i++) begin
      lf[i*2 +: 2] = l[i] ? (s[i] ? 2'h2 : 2'h1) : 2'h0;
    end
  endfunction
  task automatic test_done;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard
  initial begin
    tk(8 * GATE + 3000);
    errors++;
    test_done;
  end
  // Main sequence
  initial begin
    int pf, au;
    logic [31:0] v;
    logic [31:0] e;
    logic [2:0] exp_src;
    void'($urandom(42663));
    tk(3);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    tk(1);
    cmp({slave, src}, 32'h3);
    bus(1'b1, 8'h18, 32'hffff_ffff);
    rd(8'h18, 32'hffff_ffff, 32'h0);
    rd(8'h00, 32'hffff_ffff, 32'h0);
    // Preferred code 3 is refused and stored as word clock
    bus(1'b1, 8'h00, 32'h0000_0007);
    rd(8'h00, 32'h0000_0007, 32'h0000_0001);
    for (int k = 0; k < 24; k++) begin
      pf = $urandom % 3;
      au = $urandom % 4 != 0;
      v = $urandom;
      bus(1'b1, 8'h00, {pf[1:0], au[0]});
      cur = au ? pick(pf, on, cur) : 3;
      on <= v[2:0];
      syn <= v[5:3];
      tk(2);
      cur = au ? pick(pf, v[2:0], cur) : 3;
      exp_src = {cur != 3, cur[1:0]};
      cmp({slave, src}, exp_src);
      e = {exp_src, lf(v[2:0], v[5:3])};
      rd(8'h04, 32'h0000_07ff, e);
      cmp(irq, 1'b0);
    end
    on <= 3'h5;
    per <= 12'h504;
    bus(1'b1, 8'h00, 32'h0000_0001);
    tk(2 * GATE + 4);
    e = {16'(GATE / 5), 16'(GATE / 4)};
    rd(8'h08, 32'hffff_ffff, e);
    for (int p = 1; p < 3; p++) begin
      per <= {8'h50, p[3:0]};
      bus(1'b1, 8'h00, 32'h0000_0009);
      tk(2 * GATE + 4);
      cmp(div2, GATE / p >= 520);
    end
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 8'h00, {m[1], 4'h0, m[0], 3'h0});
      tk(1);
      cmp(div2, m == 3);
    end
    box_p <= 1'b1;
    tk(2);
    rd(8'h04, 32'h0000_0600, 32'h0000_0200);
    box_f <= 1'b1;
    tk(2);
    for (int k = 0; k < 6; k++) begin
      v = $urandom & 32'h0000_00f0;
      bus(1'b1, 8'h00, v);
      tk(1);
      e = {v[4], v[5], v[6], !v[7], 1'b1};
      cmp({oopt, iopt, meta, link, coax}, e);
      rd(8'h04, 32'h0000_0600, {v[7] ? 2'h3 : 2'h2, 9'h0});
    end
    bus(1'b1, 8'h10, 32'h0000_000f);
    rd(8'h0c, 32'h0, 32'h0);
    cmp(irq, 1'b0);
    on <= ~on;
    tk(3);
    cmp(irq, 1'b1);
    rd(8'h0c, 32'h0000_0002, 32'h0000_0002);
    tk(1);
    cmp(irq, 1'b0);
    bus(1'b1, 8'h10, 32'h0);
    on <= ~on;
    tk(3);
    cmp(irq, 1'b0);
    fl_done <= 1'b1;
    tk(1);
    fl_done <= 1'b0;
    rd(8'h14, 32'h0000_0004, 32'h0000_0004);
    fl_fail <= 1'b1;
    tk(1);
    fl_fail <= 1'b0;
    rst_i <= 1'b1;
    tk(1);
    rst_i <= 1'b0;
    tk(2);
    cmp(bkp, 1'b0);
    rd(8'h14, 32'h0000_0003, 32'h0000_0002);
    por_i <= 1'b1;
    tk(1);
    por_i <= 1'b0;
    tk(2);
    cmp(bkp, 1'b1);
    rd(8'h14, 32'h0000_0007, 32'h0000_0001);
    test_done;
  end
endmodule
`default_nettype wire

//--- dv/crs_src_model.sv
// Behavioural model of the three external clock references
`timescale 1ns/1ps
`default_nettype none
module crs_src_model (
  input wire logic clk_i,
  input wire logic [2:0] on_i,
  input wire logic [2:0] syn_i,
  input wire logic [11:0] per_i,
  output logic [2:0] lock_o,
  output logic [2:0] sync_o,
  output logic [2:0] tick_o
);
  logic [3:0] cnt [3] = '{4'h0, 4'h0, 4'h0};
  // Lock follows signal presence; sync only with lock
  assign lock_o = on_i;
  assign sync_o = on_i & syn_i;
  // Ticks only from live sources, silent lines stay low
  assign tick_o = on_i & {cnt[2] == 4'h0, cnt[1] == 4'h0, cnt[0] == 4'h0};
  // Sample period counters
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      cnt[i] <= (cnt[i] == 4'h0) ? per_i[i*4 +: 4] - 4'h1 : cnt[i] - 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- inc/crs_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH

// Register byte offsets
`define CRS_CTRL_OFS 8'h00
`define CRS_STATUS_OFS 8'h04
`define CRS_RATE_OFS 8'h08
`define CRS_IRQ_STAT_OFS 8'h0C
`define CRS_IRQ_MASK_OFS 8'h10
`define CRS_FW_OFS 8'h14

// Control field positions
`define CRS_CTRL_AUTO 0
`define CRS_CTRL_PREF_LSB 1
`define CRS_CTRL_SINGLE_SPEED 3
`define CRS_CTRL_SPDIF_OUT_OPT 4
`define CRS_CTRL_SPDIF_IN_OPT 5
`define CRS_CTRL_METADATA 6
`define CRS_CTRL_DISCONNECT 7
`define CRS_CTRL_INT_DOUBLE 8
`define CRS_CTRL_WIDTH 9
`define CRS_CTRL_RESET 9'h000

// Status field positions
`define CRS_ST_LOCK_LSB 0
`define CRS_ST_ACTIVE_LSB 6
`define CRS_ST_SLAVE 8
`define CRS_ST_BOX_LSB 9

// Interrupt event bits
`define CRS_IRQ_REF_CHANGE 0
`define CRS_IRQ_LOCK_CHANGE 1
`define CRS_IRQ_BOX_CHANGE 2
`define CRS_IRQ_FLASH_FAIL 3
`define CRS_IRQ_WIDTH 4

// Firmware status fields
`define CRS_FW_BOOT_BACKUP 0
`define CRS_FW_FAIL_PENDING 1
`define CRS_FW_NEW_PENDING 2

// Rate measurement: unit is 100 Hz, gate time in milliseconds
`define CRS_CLK_HZ 10000000
`define CRS_GATE_MS 10
`define CRS_GATE_CYCLES (`CRS_CLK_HZ / 1000 * `CRS_GATE_MS)
`define CRS_SINGLE_MAX_RATE 16'h01E0
`define CRS_DOUBLE_MIN_RATE 16'h0208

`endif

//--- inc/crs_pkg.sv
// Types shared by the clock reference select block
package crs_pkg;

  // Reference source codes; NONE means running on the oscillator
  typedef enum logic [1:0] {
    CRS_REF_WCLK,
    CRS_REF_OPTICAL,
    CRS_REF_SPDIF,
    CRS_REF_NONE
  } crs_ref_t;

  // Per-input lock indication
  typedef enum logic [1:0] {
    CRS_NO_LOCK,
    CRS_LOCK,
    CRS_SYNC,
    CRS_LOCK_RSVD
  } crs_lock_t;

  // Remote box link state
  typedef enum logic [1:0] {
    CRS_BOX_ERROR,
    CRS_BOX_DETECTED,
    CRS_BOX_CONNECTED,
    CRS_BOX_DISCONNECTED
  } crs_box_t;

  // Control register contents
  typedef struct packed {
    logic int_double;
    logic disconnect;
    logic metadata;
    logic spdif_in_opt;
    logic spdif_out_opt;
    logic single_speed;
    logic [1:0] pref;
    logic automatic_reference_mode;
  } crs_ctrl_t;

  // Wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } crs_wb_req_t;

endpackage

//--- verilog/crs_clock_ref_select.sv
// Clock reference selection, lock status and link state with Wishbone regs
//
// Function
// - Master uses oscillator, automatic uses preferred reference
// - Unusable preferred input falls back to next; here a usable current reference is kept before the next
// - Candidates: word clock, optical, SPDIF only
// - Report no lock, lock or sync per input
// - Report active reference and its measured rate
// - System clock state reads master or slave
// - Single speed halves double-rate word clock output
// - Coax SPDIF always driven, optical optional
// - SPDIF receiver input selects coax or optical
// - Measure SPDIF input rate, readable
// - Box link: error, detected, connected, disconnected
// - Disconnect stops link, box runs alone
// - Metadata option enables status and marker transfer
// - Settings act right after the write
// - Failed flash selects backup image at cold start
// - New firmware acts only after power-off
// - No valid input reverts to oscillator
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "crs_map.svh"
`default_nettype none

module crs_clock_ref_select
  import crs_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = `CRS_GATE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [2:0] ref_lock_i,
  input wire logic [2:0] ref_sync_i,
  input wire logic [2:0] ref_tick_i,
  input wire logic box_present_i,
  input wire logic box_fw_loaded_i,
  input wire logic flash_fail_i,
  input wire logic flash_done_i,
  output logic [1:0] clk_src_o,
  output logic slave_o,
  output logic wclk_div2_o,
  output logic spdif_coax_out_en_o,
  output logic spdif_opt_out_en_o,
  output logic spdif_in_opt_o,
  output logic metadata_en_o,
  output logic box_link_en_o,
  output logic boot_backup_o,
  output logic irq_o
);

  localparam logic [16:0] GATE_LAST = 17'(GATE_CYCLES - 1);

  // Next candidate after a source, wrapping over the three inputs
  function automatic crs_ref_t next_ref(input crs_ref_t r);
    case (r)
      CRS_REF_WCLK: next_ref = CRS_REF_OPTICAL;
      CRS_REF_OPTICAL: next_ref = CRS_REF_SPDIF;
      default: next_ref = CRS_REF_WCLK;
    endcase
  endfunction

  // Lock state of one input
  function automatic crs_lock_t lock_of(input logic lk, input logic sy);
    lock_of = !lk ? CRS_NO_LOCK : (sy ? CRS_SYNC : CRS_LOCK);
  endfunction

  // Lock bit of a source, NONE never counts
  function automatic logic usable(input crs_ref_t r, input logic [2:0] lk);
    usable = (r != CRS_REF_NONE) && lk[r];
  endfunction

  // Add one tick to a gated count; shared by both rate counters
  function automatic logic [15:0] cnt_step(input logic [15:0] c,
                                           input logic t);
    cnt_step = c + 16'(t);
  endfunction

  // Bus side and settings
  crs_wb_req_t req;
  crs_ctrl_t ctrl;
  crs_ref_t active;
  crs_box_t box;
  logic [`CRS_IRQ_WIDTH-1:0] irq_stat;
  logic [`CRS_IRQ_WIDTH-1:0] irq_mask;

  // Reference and lock state
  logic [5:0] lock_st;
  logic [2:0] lock_prev;

  // Rate measurement
  logic [16:0] gate_cnt;
  logic [15:0] act_cnt;
  logic [15:0] spdif_cnt;
  logic [15:0] act_rate;
  logic [15:0] spdif_rate;

  // Firmware image state
  logic fail_pending;
  logic new_pending;
  logic boot_backup;

  // Bundle the bus request
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                 sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

  // Bus decode
  // A request is taken only while ack is low, so a held
  // cycle is never answered twice
  wire bus_req = req.cyc && req.stb && !wb_ack_o;
  wire bus_wr = bus_req && req.we;
  wire bus_rd = bus_req && !req.we;
  wire hit_ctrl = req.adr == `CRS_CTRL_OFS;
  wire hit_stat = req.adr == `CRS_STATUS_OFS;
  wire hit_rate = req.adr == `CRS_RATE_OFS;
  wire hit_irq = req.adr == `CRS_IRQ_STAT_OFS;
  wire hit_mask = req.adr == `CRS_IRQ_MASK_OFS;
  wire hit_fw = req.adr == `CRS_FW_OFS;

  // Byte-lane merge of control writes
  wire [31:0] ctrl_word = {23'h00_0000, ctrl};
  wire [31:0] ctrl_merged = {
    req.sel[3] ? req.dat[31:24] : ctrl_word[31:24],
    req.sel[2] ? req.dat[23:16] : ctrl_word[23:16],
    req.sel[1] ? req.dat[15:8] : ctrl_word[15:8],
    req.sel[0] ? req.dat[7:0] : ctrl_word[7:0]};
  wire [`CRS_CTRL_WIDTH-1:0] ctrl_new = ctrl_merged[`CRS_CTRL_WIDTH-1:0];
  wire [1:0] pref_wr = ctrl_new[`CRS_CTRL_PREF_LSB +: 2];
  // Preferred code 3 is not a source; fold it onto word clock
  wire [1:0] pref_fix = (pref_wr == 2'h3) ? 2'h0 : pref_wr;
  wire [`CRS_CTRL_WIDTH-1:0] ctrl_fixed = {
    ctrl_new[`CRS_CTRL_WIDTH-1:`CRS_CTRL_PREF_LSB+2], pref_fix,
    ctrl_new[`CRS_CTRL_AUTO]};

  // Reference selection
  // Priority: preferred, then the current one so a locked
  // reference is not dropped for another input, then the
  // others in turn, then the oscillator
  crs_ref_t pref_ref;
  crs_ref_t cand1;
  crs_ref_t cand2;
  crs_ref_t next_active;
  assign pref_ref = crs_ref_t'(ctrl.pref);
  assign cand1 = next_ref(pref_ref);
  assign cand2 = next_ref(cand1);
  assign next_active =
    !ctrl.automatic_reference_mode ? CRS_REF_NONE :
    usable(pref_ref, ref_lock_i) ? pref_ref :
    usable(active, ref_lock_i) ? active :
    usable(cand1, ref_lock_i) ? cand1 :
    usable(cand2, ref_lock_i) ? cand2 :
    CRS_REF_NONE;

  // Box link state from presence, firmware and disconnect
  // Absence outranks disconnect: an unpowered box cannot run
  crs_box_t next_box;
  assign next_box =
    !box_present_i ? CRS_BOX_ERROR :
    ctrl.disconnect ? CRS_BOX_DISCONNECTED :
    !box_fw_loaded_i ? CRS_BOX_DETECTED :
    CRS_BOX_CONNECTED;

  // Per-input lock reporting
  // Sync is only shown for an input that is locked
  wire [5:0] next_lock_st = {lock_of(ref_lock_i[2], ref_sync_i[2]),
                             lock_of(ref_lock_i[1], ref_sync_i[1]),
                             lock_of(ref_lock_i[0], ref_sync_i[0])};

  // Rate gate and tick sources
  wire gate_end = gate_cnt == GATE_LAST;
  wire act_tick = usable(active, 3'b111) && ref_tick_i[active];
  wire spdif_tick = ref_tick_i[CRS_REF_SPDIF];

  // Events feeding the sticky status
  // Lock changes are seen against the last cycle, so the first
  // cycle after reset may flag inputs that are already locked
  wire [`CRS_IRQ_WIDTH-1:0] irq_evt = {
    flash_fail_i,
    box != next_box,
    lock_prev != ref_lock_i,
    active != next_active};
  wire irq_rd_clr = bus_rd && hit_irq;
  wire [`CRS_IRQ_WIDTH-1:0] next_irq_stat =
    irq_evt | (irq_rd_clr ? {`CRS_IRQ_WIDTH{1'b0}} : irq_stat);

  // Word clock divides only for double rate with single speed set
  // Rate is measured over a gate, so a new reference shows its
  // true rate only at the end of the first full gate after the switch
  wire dbl_rate = (active == CRS_REF_NONE) ? ctrl.int_double :
                  (act_rate >= `CRS_DOUBLE_MIN_RATE);
  wire next_wclk_div2 = ctrl.single_speed && dbl_rate;

  // Read multiplexer
  // Unmapped addresses read as zero
  wire [31:0] stat_word = {21'h00_0000, box, active != CRS_REF_NONE,
                           active, lock_st};
  wire [31:0] fw_word = {29'h0000_0000, new_pending, fail_pending,
                         boot_backup};
  wire [31:0] rd_data =
    hit_ctrl ? ctrl_word :
    hit_stat ? stat_word :
    hit_rate ? {spdif_rate, act_rate} :
    hit_irq ? {28'h000_0000, irq_stat} :
    hit_mask ? {28'h000_0000, irq_mask} :
    hit_fw ? fw_word :
    32'h0000_0000;

  // Bus answer: one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_rd ? rd_data : 32'h0000_0000;
    end
  end

  // Control and mask registers, effective on the write edge
  // A write with no byte lane set changes nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= crs_ctrl_t'(`CRS_CTRL_RESET);
      irq_mask <= {`CRS_IRQ_WIDTH{1'b0}};
    end else begin
      if (bus_wr && hit_ctrl && req.sel != 4'h0) begin
        ctrl <= crs_ctrl_t'(ctrl_fixed);
      end
      if (bus_wr && hit_mask && req.sel[0]) begin
        irq_mask <= req.dat[`CRS_IRQ_WIDTH-1:0];
      end
    end
  end

  // Reference, lock and link state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active <= CRS_REF_NONE;
      box <= CRS_BOX_ERROR;
      lock_st <= 6'h00;
      lock_prev <= 3'h0;
    end else begin
      active <= next_active;
      box <= next_box;
      lock_st <= next_lock_st;
      lock_prev <= ref_lock_i;
    end
  end

  // Sticky interrupt status, set wins over read clear
  // An event in the clearing cycle stays set, so none is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= {`CRS_IRQ_WIDTH{1'b0}};
      irq_o <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_o <= |(next_irq_stat & irq_mask);
    end
  end

  // Gated tick counters for rate measurement, unit 100 Hz
  // The tick of the last gate cycle is folded into the stored rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_cnt <= 17'h0_0000;
      act_cnt <= 16'h0000;
      spdif_cnt <= 16'h0000;
      act_rate <= 16'h0000;
      spdif_rate <= 16'h0000;
    end else if (gate_end) begin
      gate_cnt <= 17'h0_0000;
      act_cnt <= 16'h0000;
      spdif_cnt <= 16'h0000;
      act_rate <= cnt_step(act_cnt, act_tick);
      spdif_rate <= cnt_step(spdif_cnt, spdif_tick);
    end else begin
      gate_cnt <= gate_cnt + 17'h0_0001;
      act_cnt <= cnt_step(act_cnt, act_tick);
      spdif_cnt <= cnt_step(spdif_cnt, spdif_tick);
    end
  end

  // Pin controls driven from the current settings
  // Coax output is never switched off; optical is an addition
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_src_o <= CRS_REF_NONE;
      slave_o <= 1'b0;
      wclk_div2_o <= 1'b0;
      spdif_coax_out_en_o <= 1'b1;
      spdif_opt_out_en_o <= 1'b0;
      spdif_in_opt_o <= 1'b0;
      metadata_en_o <= 1'b0;
      box_link_en_o <= 1'b0;
    end else begin
      clk_src_o <= next_active;
      slave_o <= next_active != CRS_REF_NONE;
      wclk_div2_o <= next_wclk_div2;
      spdif_coax_out_en_o <= 1'b1;
      spdif_opt_out_en_o <= ctrl.spdif_out_opt;
      spdif_in_opt_o <= ctrl.spdif_in_opt;
      metadata_en_o <= ctrl.metadata;
      box_link_en_o <= !ctrl.disconnect;
    end
  end

  // Firmware image choice, untouched by warm reset
  // Only the cold reset loads the image choice; a warm reset
  // keeps the programming that is running
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      boot_backup <= fail_pending;
      boot_backup_o <= fail_pending;
      fail_pending <= 1'b0;
      new_pending <= 1'b0;
    end else begin
      boot_backup_o <= boot_backup;
      if (flash_fail_i) begin
        fail_pending <= 1'b1;
      end else if (flash_done_i) begin
        fail_pending <= 1'b0;
        new_pending <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire
